// [ioxp_host_model.sv]
`timescale 1ns/10ps
module ioxp_host_model (
  // clock
  input  wire logic sys_clk,
  // bus
  input  wire logic sda_oe_n,
  output logic      scl,
  output wire       sda
);
  logic pull_r;
  // open drain with pull-up
  assign sda = !(pull_r || !sda_oe_n);
  initial begin
    scl    = 1'b1;
    pull_r = 1'b0;
  end
  task automatic ph();
    repeat (6) @(negedge sys_clk);
  endtask
  // data moves only while scl low
  task automatic bit1(input logic b, output logic r);
    repeat (2) @(negedge sys_clk);
    pull_r = !b;
    ph();
    scl = 1'b1;
    ph();
    r   = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    repeat (2) @(negedge sys_clk);
    pull_r = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    pull_r = 1'b1;
    ph();
    scl = 1'b0;
  endtask
  task automatic stop();
    repeat (2) @(negedge sys_clk);
    pull_r = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    pull_r = 1'b0;
    ph();
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit1(d[i], r);
    end
    bit1(1'b1, ack);
  endtask
  task automatic rb(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit1(1'b1, r);
      d[i] = r;
    end
    bit1(nak, r);
  endtask
  task automatic rdbeg(input logic [7:0] wa, input logic [7:0] cmd);
    logic ak;
    start();
    wb(wa, ak);
    wb(cmd, ak);
    start();
    wb(wa | 8'h01, ak);
  endtask
endmodule

// [ioxp_monitor.sv]
`timescale 1ns/10ps
module ioxp_monitor #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire logic              reset_n_pin,
  // bus
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_oe_n,
  // ports
  input wire logic [PORT_W-1:0] p0_in,
  input wire logic [PORT_W-1:0] p1_in,
  input wire logic [PORT_W-1:0] p0_out,
  input wire logic [PORT_W-1:0] p1_out,
  input wire logic [PORT_W-1:0] p0_oe_n,
  input wire logic [PORT_W-1:0] p1_oe_n,
  // alert
  input wire logic              alert_out,
  input wire logic              alert_oe_n
);
  logic [2*PORT_W-1:0] pins_r;
  logic [9:0]          quiet_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ************************************************************
  // cycles since any port input pin moved
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    pins_r <= {p1_in, p0_in};
  end
  always_ff @(posedge sys_clk) begin
    if (srst || pins_r != {p1_in, p0_in}) begin
      quiet_r <= 10'h000;
    end else if (quiet_r != 10'h3ff) begin
      quiet_r <= quiet_r + 10'h001;
    end
  end
  reset_sync_a: assert property (disable iff (1'b0) srst |=> sda_oe_n && alert_oe_n
    && p0_out == {PORT_W{1'b1}} && p1_oe_n == {PORT_W{1'b1}}) else $error("reset state");
  reset_pin_a: assert property (!reset_n_pin [*4] |=> sda_oe_n && alert_oe_n
    && p1_out == {PORT_W{1'b1}} && p0_oe_n == {PORT_W{1'b1}}) else $error("pin reset");
  alert_od_a: assert property (alert_out == 1'b0) else $error("alert drives high");
  out_no_alert_a: assert property ($fell(alert_oe_n) |->
    $past(p0_oe_n) != '0 || $past(p1_oe_n) != '0) else $error("alert from outputs");
  alert_delay_a: assert property ($fell(alert_oe_n) |-> quiet_r > 10'd400)
    else $error("alert too early");
  stop_clear_a: assert property (scl_in && $rose(sda_in) |-> ##[1:12] alert_oe_n)
    else $error("stop kept alert");
  sda_edge_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda moved with scl high");
  ack_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("low bit too short");
  out_stable_a: assert property (($changed(p0_out) || $changed(p1_out)
    || $changed(p0_oe_n) || $changed(p1_oe_n)) && reset_n_pin && $past(reset_n_pin, 4)
    |-> !scl_in) else $error("outputs moved outside ack");
  cover property ($fell(alert_oe_n));
  cover property (scl_in && $rose(sda_in));
  cover property ($fell(sda_oe_n));
endmodule

bind ioxp_top ioxp_monitor #(.PORT_W(PORT_W)) i_ioxp_monitor (
  .sys_clk(sys_clk), .srst(srst), .reset_n_pin(reset_n_pin), .scl_in(scl_in),
  .sda_in(sda_in), .sda_oe_n(sda_oe_n), .p0_in(p0_in), .p1_in(p1_in), .p0_out(p0_out),
  .p1_out(p1_out), .p0_oe_n(p0_oe_n), .p1_oe_n(p1_oe_n), .alert_out(alert_out),
  .alert_oe_n(alert_oe_n));

// [ioxp_pkg.sv]
package ioxp_pkg;
  // ************************************************************
  // bus addressing
  // ************************************************************
  localparam logic [4:0] ADDR_BASE   = 5'h1d;  // upper five bits of 7'h74..7'h77
  localparam logic [2:0] CMD_INPUT0  = 3'h0;
  localparam logic [2:0] CMD_INPUT1  = 3'h1;
  localparam logic [2:0] CMD_OUTPUT0 = 3'h2;
  localparam logic [2:0] CMD_OUTPUT1 = 3'h3;
  localparam logic [2:0] CMD_POLAR0  = 3'h4;
  localparam logic [2:0] CMD_POLAR1  = 3'h5;
  localparam logic [2:0] CMD_CONFIG0 = 3'h6;
  localparam logic [2:0] CMD_CONFIG1 = 3'h7;
  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_OUTPUT  = 8'hff;
  localparam logic [7:0] RST_POLAR   = 8'h00;
  localparam logic [7:0] RST_CONFIG  = 8'hff;
  localparam logic [2:0] RST_CMD     = 3'h0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_PS         = 8000;
  localparam int ALERT_VALID_DELAY_NS  = 4000;
  localparam int ALERT_VALID_CYCLES    = (ALERT_VALID_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int SYNC_STAGES           = 2;
  // ************************************************************
  // bus engine states
  // ************************************************************
  typedef enum logic [2:0] {
    IOXP_IDLE   = 3'b000,
    IOXP_ADDR   = 3'b001,
    IOXP_ACK    = 3'b010,
    IOXP_WDATA  = 3'b011,
    IOXP_RDATA  = 3'b100,
    IOXP_RACK   = 3'b101,
    IOXP_IGNORE = 3'b110
  } ioxp_state_e;
endpackage

// [ioxp_sync.sv]
`timescale 1ns/10ps
module ioxp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // data
  input  wire logic [WIDTH-1:0] d_async,
  output logic      [WIDTH-1:0] q_sync
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      q_sync <= '0;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule

// [ioxp_top.sv]
`timescale 1ns/10ps
module ioxp_top
  import ioxp_pkg::*;
#(
  parameter int PORT_W = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              reset_n_pin,
  // bus pins
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_oe_n,
  output logic                   sda_out,
  // address select straps
  input  wire logic              addr_select_0,
  input  wire logic              addr_select_1,
  // port 0 pins
  input  wire logic [PORT_W-1:0] p0_in,
  output logic      [PORT_W-1:0] p0_out,
  output logic      [PORT_W-1:0] p0_oe_n,
  // port 1 pins
  input  wire logic [PORT_W-1:0] p1_in,
  output logic      [PORT_W-1:0] p1_out,
  output logic      [PORT_W-1:0] p1_oe_n,
  // alert pin, open drain
  output logic                   alert_out,
  output logic                   alert_oe_n
);
  import ioxp_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  localparam int SW = 2 * PORT_W + 5;
  logic [SW-1:0] sync_q;
  logic          scl_s;
  logic          sda_s;
  logic          rstn_s;
  logic [1:0]    asel_s;
  logic [PORT_W-1:0] p0_s;
  logic [PORT_W-1:0] p1_s;

  ioxp_sync #(.WIDTH(SW)) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d_async ({p1_in, p0_in, addr_select_1, addr_select_0, reset_n_pin, sda_in, scl_in}),
    .q_sync  (sync_q)
  );
  assign {p1_s, p0_s, asel_s, rstn_s, sda_s, scl_s} = sync_q;

  logic rst_all;
  assign rst_all = srst | ~rstn_s;

  // ************************************************************
  // bus condition detection
  // ************************************************************
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ************************************************************
  // registers
  // ************************************************************
  logic [PORT_W-1:0] out0_r;
  logic [PORT_W-1:0] out1_r;
  logic [PORT_W-1:0] pol0_r;
  logic [PORT_W-1:0] pol1_r;
  logic [PORT_W-1:0] cfg0_r;
  logic [PORT_W-1:0] cfg1_r;
  logic [PORT_W-1:0] snap0_r;
  logic [PORT_W-1:0] snap1_r;
  logic [2:0]        cmd_r;

  function automatic logic [PORT_W-1:0] reg_read(input logic [2:0] idx,
      input logic [PORT_W-1:0] i0, input logic [PORT_W-1:0] i1);
    case (idx)
      CMD_INPUT0:  reg_read = i0;
      CMD_INPUT1:  reg_read = i1;
      CMD_OUTPUT0: reg_read = out0_r;
      CMD_OUTPUT1: reg_read = out1_r;
      CMD_POLAR0:  reg_read = pol0_r;
      CMD_POLAR1:  reg_read = pol1_r;
      CMD_CONFIG0: reg_read = cfg0_r;
      default:     reg_read = cfg1_r;
    endcase
  endfunction

  logic [PORT_W-1:0] in0_val;
  logic [PORT_W-1:0] in1_val;
  assign in0_val = p0_s ^ pol0_r;
  assign in1_val = p1_s ^ pol1_r;

  // ************************************************************
  // bus engine
  // ************************************************************
  ioxp_state_e st_r;
  logic [7:0]  shift_r;
  logic [3:0]  bitcnt_r;
  logic        rw_r;
  logic        cmd_phase_r;
  logic        addr_hit;
  logic [2:0]  ptr_r;
  logic        write_stb;
  logic        rd_ack_stb;
  logic        rd_port_stb;
  logic [1:0]  rd_port_clr;
  logic        adr_ack_r;

  assign addr_hit = (shift_r[7:3] == ADDR_BASE) && (shift_r[2:1] == asel_s);

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      st_r        <= IOXP_IDLE;
      shift_r     <= 8'h00;
      bitcnt_r    <= 4'h0;
      rw_r        <= 1'b0;
      cmd_phase_r <= 1'b0;
      adr_ack_r   <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else if (start_det) begin
      st_r     <= IOXP_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      st_r     <= IOXP_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (st_r)
        IOXP_ADDR, IOXP_WDATA: begin
          if (scl_rise) begin
            shift_r  <= {shift_r[6:0], sda_s};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == 4'h8) begin
            if (st_r == IOXP_ADDR && !addr_hit) begin
              st_r <= IOXP_IGNORE;
            end else begin
              if (st_r == IOXP_ADDR) begin
                rw_r        <= shift_r[0];
                cmd_phase_r <= ~shift_r[0];
              end
              st_r     <= IOXP_ACK;
              sda_oe_n <= 1'b0;
              adr_ack_r <= (st_r == IOXP_ADDR);
            end
          end
        end
        IOXP_ACK: begin
          if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (rw_r) begin
              st_r     <= IOXP_RDATA;
              sda_oe_n <= shift_r[7];
              shift_r  <= {shift_r[6:0], 1'b1};
            end else begin
              st_r     <= IOXP_WDATA;
              sda_oe_n <= 1'b1;
            end
          end else if (scl_rise && rw_r) begin
            shift_r <= reg_read(ptr_r, in0_val, in1_val);
          end
        end
        IOXP_RDATA: begin
          if (scl_fall) begin
            bitcnt_r <= bitcnt_r + 4'h1;
            if (bitcnt_r == 4'h7) begin
              st_r     <= IOXP_RACK;
              sda_oe_n <= 1'b1;
            end else begin
              sda_oe_n <= shift_r[7];
              shift_r  <= {shift_r[6:0], 1'b1};
            end
          end
        end
        IOXP_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_r <= IOXP_IGNORE;
            end else begin
              shift_r <= reg_read({ptr_r[2:1], ~ptr_r[0]}, in0_val, in1_val);
            end
          end else if (scl_fall) begin
            st_r     <= IOXP_RDATA;
            bitcnt_r <= 4'h0;
            sda_oe_n <= shift_r[7];
            shift_r  <= {shift_r[6:0], 1'b1};
          end
        end
        IOXP_IGNORE: begin
          sda_oe_n <= 1'b1;
        end
        default: begin
          st_r <= IOXP_IDLE;
        end
      endcase
      if (st_r == IOXP_ACK && scl_fall) begin
        adr_ack_r <= 1'b0;
        if (!rw_r && !adr_ack_r) begin
          cmd_phase_r <= 1'b0;
        end
      end
    end
  end

  // write strobe at end of ack of a data byte
  assign write_stb   = (st_r == IOXP_ACK) && scl_fall && !rw_r && !cmd_phase_r && !adr_ack_r;
  // read clear at ack of a read byte, after scl falls on ack or at scl rise on nak
  assign rd_ack_stb  = (st_r == IOXP_RACK) && scl_fall;
  assign rd_port_stb = rd_ack_stb || ((st_r == IOXP_RACK) && scl_rise && sda_s);
  assign rd_port_clr = rd_port_stb ? {ptr_r == CMD_INPUT1, ptr_r == CMD_INPUT0} : 2'b00;

  // ************************************************************
  // command pointer
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      ptr_r <= RST_CMD;
      cmd_r <= RST_CMD;
    end else if (st_r == IOXP_ACK && scl_fall && !rw_r && cmd_phase_r && !adr_ack_r) begin
      cmd_r <= shift_r[2:0];
      ptr_r <= shift_r[2:0];
    end else if (start_det && st_r != IOXP_IDLE && st_r != IOXP_IGNORE) begin
      cmd_r <= ptr_r;
    end else if (write_stb || rd_ack_stb) begin
      ptr_r <= {ptr_r[2:1], ~ptr_r[0]};
    end else if (stop_det) begin
      ptr_r <= cmd_r;
    end
  end

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      out0_r <= RST_OUTPUT;
      out1_r <= RST_OUTPUT;
      pol0_r <= RST_POLAR;
      pol1_r <= RST_POLAR;
      cfg0_r <= RST_CONFIG;
      cfg1_r <= RST_CONFIG;
    end else if (write_stb) begin
      case (ptr_r)
        CMD_OUTPUT0: out0_r <= shift_r;
        CMD_OUTPUT1: out1_r <= shift_r;
        CMD_POLAR0:  pol0_r <= shift_r;
        CMD_POLAR1:  pol1_r <= shift_r;
        CMD_CONFIG0: cfg0_r <= shift_r;
        CMD_CONFIG1: cfg1_r <= shift_r;
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // port pins
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      p0_out  <= RST_OUTPUT;
      p1_out  <= RST_OUTPUT;
      p0_oe_n <= {PORT_W{1'b1}};
      p1_oe_n <= {PORT_W{1'b1}};
    end else begin
      p0_out  <= out0_r;
      p1_out  <= out1_r;
      p0_oe_n <= cfg0_r;
      p1_oe_n <= cfg1_r;
    end
  end

  // ************************************************************
  // change alert
  // ************************************************************
  logic [1:0] mism;
  logic       alert_raw;
  logic [15:0] alert_cnt_r;

  // snapshot of raw pins taken at each port read or stop
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      snap0_r <= '0;
      snap1_r <= '0;
    end else begin
      if (rd_port_clr[0] || stop_det) begin
        snap0_r <= p0_s;
      end
      if (rd_port_clr[1] || stop_det) begin
        snap1_r <= p1_s;
      end
    end
  end

  // inputs only; restoring the level drops the mismatch
  assign mism[0] = |((p0_s ^ snap0_r) & cfg0_r);
  assign mism[1] = |((p1_s ^ snap1_r) & cfg1_r);
  assign alert_raw = |mism;

  always_ff @(posedge sys_clk) begin
    if (rst_all || !alert_raw) begin
      alert_cnt_r <= 16'h0000;
    end else if (alert_cnt_r < 16'(ALERT_VALID_CYCLES)) begin
      alert_cnt_r <= alert_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      alert_oe_n <= 1'b1;
    end else begin
      alert_oe_n <= ~(alert_raw && alert_cnt_r >= 16'(ALERT_VALID_CYCLES - 1));
    end
  end

  // both pins only ever pull low
  always_ff @(posedge sys_clk) begin
    alert_out <= 1'b0;
    sda_out   <= 1'b0;
  end
endmodule

// [ioxp_top_bench.sv]
`timescale 1ns/10ps
module ioxp_top_bench;
  import ioxp_pkg::*;
  logic       sys_clk, srst, reset_n_pin;
  logic [1:0] sel;
  logic [7:0] p0_in, p1_in;
  wire        scl, sda, sda_oe_n, alert_out, alert_oe_n;
  wire  [7:0] p0_out, p1_out, p0_oe_n, p1_oe_n;
  wire        alert_line = alert_oe_n ? 1'b1 : alert_out;
  int         n_errors = 0;
  int         n_compared = 0;
  ioxp_top i_ioxp_top (.sys_clk(sys_clk), .srst(srst), .reset_n_pin(reset_n_pin),
    .scl_in(scl), .sda_in(sda), .sda_oe_n(sda_oe_n), .sda_out(),
    .addr_select_0(sel[0]), .addr_select_1(sel[1]), .p0_in(p0_in), .p0_out(p0_out),
    .p0_oe_n(p0_oe_n), .p1_in(p1_in), .p1_out(p1_out), .p1_oe_n(p1_oe_n),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  ioxp_host_model i_ioxp_host_model (.sys_clk(sys_clk), .sda_oe_n(sda_oe_n), .scl(scl),
    .sda(sda));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] wadr();
    return {ADDR_BASE, sel, 1'b0};
  endfunction
  task automatic results();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_al(input logic lvl, input int lim, output int n);
    n = 0;
    while (alert_line !== lvl && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h0, alert_line}, {7'h0, lvl});
    if (alert_line !== lvl) begin
      results();
    end
  endtask
  task automatic wr3(input logic [2:0] c, input logic [7:0] a, b, d);
    logic ak;
    i_ioxp_host_model.start();
    i_ioxp_host_model.wb(wadr(), ak);
    chk({7'h0, ak}, 8'h00);
    i_ioxp_host_model.wb({5'h00, c}, ak);
    i_ioxp_host_model.wb(a, ak);
    i_ioxp_host_model.wb(b, ak);
    i_ioxp_host_model.wb(d, ak);
    i_ioxp_host_model.stop();
  endtask
  task automatic rdchk(input logic nak, input logic [7:0] exp);
    logic [7:0] d;
    i_ioxp_host_model.rb(nak, d);
    chk(d, exp);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_write_reset();
    wr3(CMD_OUTPUT0, 8'h12, 8'h34, 8'h56);
    chk(p0_out, 8'h56);
    chk(p1_out, 8'h34);
    reset_n_pin = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(p0_out, RST_OUTPUT);
    reset_n_pin = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic t_config();
    wr3(CMD_CONFIG0, 8'h0f, 8'hf0, 8'h0f);
    chk(p0_oe_n, 8'h0f);
    chk(p1_oe_n, 8'hf0);
    wr3(CMD_CONFIG1, 8'hff, 8'hff, 8'hff);
  endtask
  task automatic t_addr();
    logic ak;
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      i_ioxp_host_model.start();
      i_ioxp_host_model.wb({ADDR_BASE, sel ^ 2'h1, 1'b0}, ak);
      chk({7'h0, ak}, 8'h01);
      i_ioxp_host_model.start();
      i_ioxp_host_model.wb(wadr(), ak);
      chk({7'h0, ak}, 8'h00);
      i_ioxp_host_model.stop();
    end
  endtask
  task automatic t_read();
    logic ak;
    p0_in = 8'hda;
    p1_in = 8'h3c;
    wr3(CMD_POLAR0, 8'h0f, 8'h00, 8'h0f);
    i_ioxp_host_model.rdbeg(wadr(), {5'h00, CMD_INPUT1});
    rdchk(1'b0, 8'h3c);
    rdchk(1'b0, 8'hd5);
    rdchk(1'b0, 8'h3c);
    // restart while port 0 is being read; its first bit is a one
    i_ioxp_host_model.start();
    i_ioxp_host_model.wb(wadr() | 8'h01, ak);
    chk({7'h0, ak}, 8'h00);
    rdchk(1'b1, 8'hd5);
    i_ioxp_host_model.stop();
    i_ioxp_host_model.start();
    i_ioxp_host_model.wb(wadr() | 8'h01, ak);
    chk({7'h0, ak}, 8'h00);
    rdchk(1'b1, 8'hd5);
    i_ioxp_host_model.stop();
  endtask
  task automatic t_alert();
    int n;
    p0_in = 8'h5b;
    wait_al(1'b0, 700, n);
    chk({7'h0, n > 400}, 8'h01);
    i_ioxp_host_model.rdbeg(wadr(), {5'h00, CMD_INPUT1});
    rdchk(1'b0, 8'h3c);
    repeat (8) @(negedge sys_clk);
    chk({7'h0, alert_line}, 8'h00);
    rdchk(1'b1, 8'h54);
    repeat (8) @(negedge sys_clk);
    chk({7'h0, alert_line}, 8'h01);
    i_ioxp_host_model.stop();
    p1_in = 8'h3d;
    wait_al(1'b0, 700, n);
    p1_in = 8'h3c;
    wait_al(1'b1, 20, n);
    p1_in = 8'h3e;
    wait_al(1'b0, 700, n);
    i_ioxp_host_model.start();
    i_ioxp_host_model.stop();
    wait_al(1'b1, 20, n);
  endtask
  task automatic t_outputs();
    wr3(CMD_CONFIG1, 8'h00, 8'hff, 8'h00);
    p1_in = 8'h00;
    repeat (700) @(negedge sys_clk);
    chk({7'h0, alert_line}, 8'h01);
  endtask
  initial begin
    srst        = 1'b1;
    reset_n_pin = 1'b1;
    sel         = 2'h0;
    p0_in       = 8'h00;
    p1_in       = 8'h00;
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    repeat (6) @(negedge sys_clk);
    t_write_reset();
    t_config();
    t_addr();
    t_read();
    t_alert();
    t_outputs();
    results();
  end
endmodule
